// file: logic/serdes_tap_pol_pkg.sv
// constants for the serdes transmit tap and pair polarity register block
// What this block does
// - register sits at offset 0x0005 of management device 0x1e, resets to 0x2000
// - bit 15 set swaps the receive pins, inverting the recovered stream
// - bit 14 set swaps the transmit outputs, inverting the serial stream
// - bit 13 is reserved, resets to one, stays readable and writable
// - bits 12:8 are sign-magnitude first post tap, 2.5 percent steps
// - bits 7:4 are sign-magnitude pre tap, 2.5 percent steps, reset zero
// - bits 3:0 are sign-magnitude second post tap, both zero codes no weight
package serdes_tap_pol_pkg;
   // -----------------------------------------
   // register map
   // -----------------------------------------
   localparam logic [4:0] DEV_ADDR = 5'h1e;
   localparam logic [15:0] REG_TAP_POL = 16'h0005;
   localparam logic [15:0] CTRL_RESET = 16'h2000;
   localparam int RX_SWAP_BIT = 15;
   localparam int TX_SWAP_BIT = 14;
   localparam int RSVD_BIT = 13;
   localparam int POST1_HI = 12;
   localparam int POST1_LO = 8;
   localparam int PRE_HI = 7;
   localparam int PRE_LO = 4;
   localparam int POST2_HI = 3;
   localparam int POST2_LO = 0;
   // -----------------------------------------
   // management frame
   // -----------------------------------------
   localparam logic [5:0] PREAMBLE_LEN = 6'h20;
   localparam logic [4:0] HEADER_LEN = 5'h0e;
   localparam logic [4:0] DATA_LEN = 5'h10;
   localparam logic [1:0] OP_ADDR = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ_INC = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;
   localparam logic [1:0] START_CODE = 2'h0;
endpackage

// file: logic/tap_weight_decode.sv
// sign-magnitude tap code to signed step count
module tap_weight_decode #(
   parameter int MAG_W = 3
) (
   input wire logic [MAG_W:0] i_code,
   output logic signed [MAG_W+1:0] o_steps
);
   logic [MAG_W+1:0] mag;

   // refused at elaboration: a sign bit alone carries no weight
   if (MAG_W < 1) begin : g_bad_width
      $error("tap magnitude width must be at least one");
   end

   // negative zero folds to zero since -0 == 0
   always_comb begin
      mag = {2'b00, i_code[MAG_W-1:0]};
      o_steps = i_code[MAG_W] ? -mag : mag;
   end
endmodule // tap_weight_decode

// file: logic/highspeed_serdes_tap_polarity_ctrl.sv
// tap and polarity control register behind a clause 45 management slave
module highspeed_serdes_tap_polarity_ctrl (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_mdc,
   input wire logic i_mdio,
   output logic o_mdio,
   output logic o_mdio_oe_n,
   input wire logic [4:0] i_port_addr,
   input wire logic i_serial_in_positive,
   input wire logic i_serial_in_negative,
   output logic o_rx_data,
   input wire logic i_tx_data,
   output logic o_serial_out_positive,
   output logic o_serial_out_negative,
   output logic o_receive_pair_swap,
   output logic o_transmit_pair_swap,
   output logic signed [5:0] o_tx_first_post_tap,
   output logic signed [4:0] o_tx_pre_tap,
   output logic signed [4:0] o_tx_second_post_tap
);
   // -----------------------------------------
   // state
   // -----------------------------------------
   typedef enum logic [3:0] {
      ST_PREAMBLE = 4'b0001,
      ST_HEADER = 4'b0010,
      ST_TURN = 4'b0100,
      ST_DATA = 4'b1000
   } frame_state_t;

   typedef struct packed {
      logic mdc_meta;
      logic mdc_sync;
      logic mdc_prev;
      logic mdio_meta;
      logic mdio_sync;
      logic [4:0] port_meta;
      logic [4:0] port_sync;
      logic rxp_meta;
      logic rxp_sync;
      logic rxn_meta;
      logic rxn_sync;
      frame_state_t state;
      logic [5:0] pre_cnt;
      logic [4:0] bit_cnt;
      logic [15:0] shift;
      logic [1:0] op;
      logic hit;
      logic [15:0] addr;
      logic [15:0] ctrl;
      logic mdio_out;
      logic mdio_oe_n;
      logic rx_data;
      logic tx_p;
      logic tx_n;
      logic signed [5:0] post1_w;
      logic signed [4:0] pre_w;
      logic signed [4:0] post2_w;
   } block_state_t;

   block_state_t s;
   block_state_t next_s;
   logic rise;
   logic [15:0] rd_data;
   logic [15:0] wr_data;
   logic signed [5:0] post1_c;
   logic signed [4:0] pre_c;
   logic signed [4:0] post2_c;

   // -----------------------------------------
   // tap decoders
   // -----------------------------------------
   tap_weight_decode #(.MAG_W(4)) u_post1 (
      .i_code(s.ctrl[serdes_tap_pol_pkg::POST1_HI:serdes_tap_pol_pkg::POST1_LO]),
      .o_steps(post1_c)
   );
   tap_weight_decode #(.MAG_W(3)) u_pre (
      .i_code(s.ctrl[serdes_tap_pol_pkg::PRE_HI:serdes_tap_pol_pkg::PRE_LO]),
      .o_steps(pre_c)
   );
   tap_weight_decode #(.MAG_W(3)) u_post2 (
      .i_code(s.ctrl[serdes_tap_pol_pkg::POST2_HI:serdes_tap_pol_pkg::POST2_LO]),
      .o_steps(post2_c)
   );

   // -----------------------------------------
   // next state
   // -----------------------------------------
   always_comb begin
      next_s = s;
      next_s.mdc_meta = i_mdc;
      next_s.mdc_sync = s.mdc_meta;
      next_s.mdc_prev = s.mdc_sync;
      next_s.mdio_meta = i_mdio;
      next_s.mdio_sync = s.mdio_meta;
      next_s.port_meta = i_port_addr;
      next_s.port_sync = s.port_meta;
      next_s.rxp_meta = i_serial_in_positive;
      next_s.rxp_sync = s.rxp_meta;
      next_s.rxn_meta = i_serial_in_negative;
      next_s.rxn_sync = s.rxn_meta;
      // recovered bit follows whichever pin is treated as positive
      next_s.rx_data = s.ctrl[serdes_tap_pol_pkg::RX_SWAP_BIT] ? s.rxn_sync
                                                               : s.rxp_sync;
      next_s.tx_p = i_tx_data ^ s.ctrl[serdes_tap_pol_pkg::TX_SWAP_BIT];
      next_s.tx_n = ~(i_tx_data ^ s.ctrl[serdes_tap_pol_pkg::TX_SWAP_BIT]);
      next_s.post1_w = post1_c;
      next_s.pre_w = pre_c;
      next_s.post2_w = post2_c;

      rise = s.mdc_sync & ~s.mdc_prev;
      // other addresses in this device read as zero
      rd_data = (s.addr == serdes_tap_pol_pkg::REG_TAP_POL) ? s.ctrl : 16'h0000;
      wr_data = {s.shift[14:0], s.mdio_sync};

      if (rise) begin
         unique case (s.state)
            ST_PREAMBLE: begin
               if (s.mdio_sync) begin
                  if (s.pre_cnt != serdes_tap_pol_pkg::PREAMBLE_LEN) begin
                     next_s.pre_cnt = s.pre_cnt + 6'h01;
                  end
               end else if (s.pre_cnt == serdes_tap_pol_pkg::PREAMBLE_LEN) begin
                  next_s.state = ST_HEADER;
                  next_s.bit_cnt = 5'h01;
                  next_s.shift = 16'h0000;
               end else begin
                  next_s.pre_cnt = 6'h00;
               end
            end
            ST_HEADER: begin
               next_s.shift = wr_data;
               next_s.bit_cnt = s.bit_cnt + 5'h01;
               if (s.bit_cnt == serdes_tap_pol_pkg::HEADER_LEN - 5'h01) begin
                  next_s.op = wr_data[11:10];
                  next_s.hit = (wr_data[9:5] == s.port_sync)
                             && (wr_data[4:0] == serdes_tap_pol_pkg::DEV_ADDR);
                  next_s.bit_cnt = 5'h00;
                  next_s.pre_cnt = 6'h00;
                  // a bad start code drops the frame
                  next_s.state = (wr_data[13:12] == serdes_tap_pol_pkg::START_CODE)
                               ? ST_TURN : ST_PREAMBLE;
               end
            end
            ST_TURN: begin
               next_s.bit_cnt = s.bit_cnt + 5'h01;
               if (s.hit && s.op[1]) begin
                  if (s.bit_cnt == 5'h00) begin
                     next_s.mdio_out = 1'b0;
                     next_s.mdio_oe_n = 1'b0;
                  end else begin
                     next_s.mdio_out = rd_data[15];
                     next_s.shift = {rd_data[14:0], 1'b0};
                  end
               end
               if (s.bit_cnt == 5'h01) begin
                  next_s.state = ST_DATA;
                  next_s.bit_cnt = 5'h00;
               end
            end
            ST_DATA: begin
               next_s.bit_cnt = s.bit_cnt + 5'h01;
               next_s.shift = s.op[1] ? {s.shift[14:0], 1'b0} : wr_data;
               if (s.hit && s.op[1]) begin
                  next_s.mdio_out = s.shift[15];
               end
               if (s.bit_cnt == serdes_tap_pol_pkg::DATA_LEN - 5'h01) begin
                  next_s.state = ST_PREAMBLE;
                  next_s.pre_cnt = 6'h00;
                  next_s.mdio_oe_n = 1'b1;
                  next_s.mdio_out = 1'b0;
                  if (s.hit) begin
                     unique case (s.op)
                        serdes_tap_pol_pkg::OP_ADDR: begin
                           next_s.addr = wr_data;
                        end
                        serdes_tap_pol_pkg::OP_WRITE: begin
                           // all 16 bits stored, reserved bit included
                           if (s.addr == serdes_tap_pol_pkg::REG_TAP_POL) begin
                              next_s.ctrl = wr_data;
                           end
                        end
                        serdes_tap_pol_pkg::OP_READ_INC: begin
                           next_s.addr = s.addr + 16'h0001;
                        end
                        serdes_tap_pol_pkg::OP_READ: begin
                           next_s.addr = s.addr;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // -----------------------------------------
   // registers
   // -----------------------------------------
   always_ff @(posedge i_clk_sys) begin
      if (!i_reset_n) begin
         s <= '0;
         s.state <= ST_PREAMBLE;
         s.ctrl <= serdes_tap_pol_pkg::CTRL_RESET;
         s.mdio_oe_n <= 1'b1;
         s.tx_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_mdio = s.mdio_out;
   assign o_mdio_oe_n = s.mdio_oe_n;
   assign o_rx_data = s.rx_data;
   assign o_serial_out_positive = s.tx_p;
   assign o_serial_out_negative = s.tx_n;
   assign o_receive_pair_swap = s.ctrl[serdes_tap_pol_pkg::RX_SWAP_BIT];
   assign o_transmit_pair_swap = s.ctrl[serdes_tap_pol_pkg::TX_SWAP_BIT];
   assign o_tx_first_post_tap = s.post1_w;
   assign o_tx_pre_tap = s.pre_w;
   assign o_tx_second_post_tap = s.post2_w;
endmodule // highspeed_serdes_tap_polarity_ctrl

// file: test/serdes_remote_model.sv
// far-end transceiver model: drives the receive pair, recovers the transmit pair
module serdes_remote_model (
   input wire logic i_clk_sys,
   input wire logic i_bit,
   input wire logic i_line_p,
   input wire logic i_line_n,
   output logic o_pos = 1'b0,
   output logic o_neg = 1'b1,
   output logic o_bit
);
   timeunit 1ns;
   timeprecision 1ps;
   // pair always complementary, so a swap inverts the bit seen
   always @(posedge i_clk_sys) begin
      o_pos <= i_bit;
      o_neg <= ~i_bit;
   end
   assign o_bit = i_line_p & ~i_line_n;
endmodule // serdes_remote_model

// file: test/serdes_tap_pol_assertions.sv
// port checks for the tap and polarity register block
module serdes_tap_pol_assertions (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic i_tx_data,
   input wire logic i_serial_in_positive,
   input wire logic i_serial_in_negative,
   input wire logic o_mdio,
   input wire logic o_mdio_oe_n,
   input wire logic o_rx_data,
   input wire logic o_serial_out_positive,
   input wire logic o_serial_out_negative,
   input wire logic o_receive_pair_swap,
   input wire logic o_transmit_pair_swap,
   input wire logic signed [5:0] o_tx_first_post_tap,
   input wire logic signed [4:0] o_tx_pre_tap,
   input wire logic signed [4:0] o_tx_second_post_tap
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   AST_RST_VAL: assert property (!$past(i_reset_n) |-> o_mdio_oe_n && o_tx_pre_tap == 0
      && !o_receive_pair_swap && !o_transmit_pair_swap) else $error("reset value wrong");
   AST_TX_POS: assert property ($past(i_reset_n) && $stable(o_transmit_pair_swap)
      |-> o_serial_out_positive == ($past(i_tx_data) ^ o_transmit_pair_swap))
      else $error("tx positive wrong");
   AST_TX_NEG: assert property (o_serial_out_negative == !o_serial_out_positive)
      else $error("tx pair not complementary");
   // swap must be settled over the sync depth or the pin choice is ambiguous
   AST_RX_SEL: assert property ($past(i_reset_n) && $past(i_reset_n, 2)
      && $past(i_reset_n, 3) && $past(i_reset_n, 4)
      && o_receive_pair_swap == $past(o_receive_pair_swap, 4) |-> o_rx_data ==
      (o_receive_pair_swap ? $past(i_serial_in_negative, 3) : $past(i_serial_in_positive, 3)))
      else $error("rx pin choice wrong");
   AST_POST1_RNG: assert property (o_tx_first_post_tap >= -6'sd15
      && o_tx_first_post_tap <= 6'sd15) else $error("post1 out of range");
   AST_PRE_RNG: assert property (o_tx_pre_tap >= -5'sd7 && o_tx_pre_tap <= 5'sd7)
      else $error("pre out of range");
   AST_POST2_RNG: assert property (o_tx_second_post_tap >= -5'sd7
      && o_tx_second_post_tap <= 5'sd7) else $error("post2 out of range");
   AST_OE_TA: assert property ($fell(o_mdio_oe_n) |-> !o_mdio ##1 !o_mdio_oe_n [*8])
      else $error("turnaround drive wrong");
   AST_OE_END: assert property ($fell(o_mdio_oe_n) |-> ##[100:300] o_mdio_oe_n)
      else $error("read drive not released");
endmodule // serdes_tap_pol_assertions
bind highspeed_serdes_tap_polarity_ctrl serdes_tap_pol_assertions u_chk (.i_clk_sys,
   .i_reset_n, .i_tx_data, .i_serial_in_positive, .i_serial_in_negative, .o_mdio,
   .o_mdio_oe_n, .o_rx_data, .o_serial_out_positive, .o_serial_out_negative,
   .o_receive_pair_swap, .o_transmit_pair_swap, .o_tx_first_post_tap, .o_tx_pre_tap,
   .o_tx_second_post_tap);

// file: test/tb.sv
// self-checking bench for the tap and polarity register block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic mdc = 1'b0;
   logic tb_mdio = 1'b1;
   logic tx_bit = 1'b0;
   logic rx_bit = 1'b0;
   logic mdio_w, rxp, rxn, o_mdio, oe_n, rx_data, txp, txn, rsw, tsw, far_bit;
   logic signed [5:0] post1;
   logic signed [4:0] pre, post2;
   logic [15:0] rd_word, v;
   logic [15:0] exp_q[$];
   logic [15:0] vals[4] = '{16'hffff, 16'h9888, 16'h2000, 16'h6f77};
   int err_total = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   // pulled-up wire: bench releases to one while the block drives
   assign mdio_w = oe_n ? tb_mdio : o_mdio;
   highspeed_serdes_tap_polarity_ctrl u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_mdc(mdc),
      .i_mdio(mdio_w), .o_mdio(o_mdio), .o_mdio_oe_n(oe_n), .i_port_addr(5'h03),
      .i_serial_in_positive(rxp), .i_serial_in_negative(rxn), .o_rx_data(rx_data),
      .i_tx_data(tx_bit), .o_serial_out_positive(txp), .o_serial_out_negative(txn),
      .o_receive_pair_swap(rsw), .o_transmit_pair_swap(tsw), .o_tx_first_post_tap(post1),
      .o_tx_pre_tap(pre), .o_tx_second_post_tap(post2));
   serdes_remote_model u_far (.i_clk_sys(clk), .i_bit(rx_bit), .i_line_p(txp),
      .i_line_n(txn), .o_pos(rxp), .o_neg(rxn), .o_bit(far_bit));
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string nm);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   function automatic logic [15:0] steps(input logic [4:0] c, input int w);
      int m;
      m = c & ((1 << w) - 1);
      return 16'(c[w] ? -m : m);
   endfunction
   // read frames release the wire from turnaround on and sample before each data edge
   task automatic frame(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d);
      logic [63:0] f;
      f = {32'hffffffff, 2'b00, op, 5'h03, dev, op[1] ? 2'b11 : 2'b10, op[1] ? 16'hffff : d};
      for (int i = 63; i >= 0; i--) begin
         tb_mdio = f[i];
         repeat (4) @(negedge clk);
         if (i < 16) rd_word[i] = o_mdio;
         mdc = 1'b1;
         repeat (4) @(negedge clk);
         mdc = 1'b0;
      end
   endtask
   task automatic acc(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d);
      frame(serdes_tap_pol_pkg::OP_ADDR, dev, serdes_tap_pol_pkg::REG_TAP_POL);
      frame(op, dev, d);
   endtask
   task automatic rd(input logic [15:0] e);
      exp_q.push_back(e);
      acc(serdes_tap_pol_pkg::OP_READ, serdes_tap_pol_pkg::DEV_ADDR, 16'h0000);
   endtask
   always @(posedge oe_n) begin
      if (rst_n === 1'b1 && exp_q.size() > 0) chk(rd_word, exp_q.pop_front(), "rd_word");
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      finish_test();
   end
   initial begin
      void'($urandom(32'h73e9d5a9));
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(16'(pre), 16'h0000, "pre_reset");
      rd(serdes_tap_pol_pkg::CTRL_RESET);
      for (int k = 0; k < 8; k++) begin
         v = k < 4 ? vals[k] : 16'($urandom);
         v[13] = 1'b1;
         tx_bit = 1'($urandom);
         rx_bit = 1'($urandom);
         acc(serdes_tap_pol_pkg::OP_WRITE, serdes_tap_pol_pkg::DEV_ADDR, v);
         repeat (6) @(negedge clk);
         chk(16'(rsw), 16'(v[15]), "rx_swap");
         chk(16'(rx_data), 16'(rx_bit ^ v[15]), "rx_data");
         chk(16'(tsw), 16'(v[14]), "tx_swap");
         chk(16'(far_bit), 16'(tx_bit ^ v[14]), "tx_line");
         chk(16'(post1), steps(v[12:8], 4), "post1");
         chk(16'(pre), steps({1'b0, v[7:4]}, 3), "pre");
         chk(16'(post2), steps({1'b0, v[3:0]}, 3), "post2");
         acc(serdes_tap_pol_pkg::OP_WRITE, 5'h1d, ~v);
         rd(v);
      end
      // read-increment, then a read and a write one address above the register
      exp_q.push_back(v);
      acc(serdes_tap_pol_pkg::OP_READ_INC, serdes_tap_pol_pkg::DEV_ADDR, 16'h0000);
      exp_q.push_back(16'h0000);
      frame(serdes_tap_pol_pkg::OP_READ, serdes_tap_pol_pkg::DEV_ADDR, 16'h0000);
      frame(serdes_tap_pol_pkg::OP_WRITE, serdes_tap_pol_pkg::DEV_ADDR, ~v);
      rd(v);
      // mid-run reset must bring the register back to its default
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      chk(16'({rsw, tsw}), 16'h0000, "swap_reset");
      rd(serdes_tap_pol_pkg::CTRL_RESET);
      repeat (8) @(negedge clk);
      chk(16'(exp_q.size()), 16'h0000, "pending_reads");
      finish_test();
   end
endmodule // tb
